/* File: fdd_power_config_regs.sv */
// configuration registers for drive type ids, auto power-down and boot drive
// assumes index/data strobes are one-cycle pulses on the core clock, and that
// the configuration-state flag comes from the config port logic
`timescale 1ns/10ps
module fdd_power_config_regs (
    // clock and power-on reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // hardware reset pin, asynchronous to the core clock
    input wire logic i_hard_reset_pin,
    // configuration port
    input wire logic i_config_state,
    input wire logic i_index_wr,
    input wire logic i_data_wr,
    input wire logic i_data_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    // floppy setup fields, owned elsewhere
    input wire logic i_floppy_outputs_tristate,
    input wire logic i_density_override,
    input wire logic i_density_func,
    input wire logic i_pport_floppy_active,
    // density pin
    output logic o_density_select_out,
    output logic o_density_select_oe_n,
    output logic o_pport_density_out,
    // decoded fields
    output logic [7:0] o_drive_type_id,
    output logic [1:0] o_drive0_type,
    output logic [1:0] o_drive1_type,
    output logic [1:0] o_drive2_type,
    output logic [1:0] o_drive3_type,
    output logic [1:0] o_boot_floppy,
    output logic o_boot_drive_b,
    output logic o_pd_parallel_en,
    output logic o_pd_second_serial_en,
    output logic o_pd_first_serial_en,
    output logic o_pd_floppy_en,
    output logic [7:0] o_test_control
);
    import cfg_regs_pkg::*;

    typedef struct packed {
        logic [7:0] config_index_reg;
        logic [7:0] drive_type_id;
        logic [7:0] auto_powerdown_boot_select;
        logic [7:0] test_control;
        logic [7:0] rdata;
        logic rdata_valid;
        logic pport_density;
    } reg_state_t;

    reg_state_t state;
    reg_state_t next_state;
    logic hard_reset_sync;
    logic hard_rise;
    logic [1:0] drive_type [NUM_DRIVES];
    logic cfg_wr;
    logic cfg_rd;

    // hardware reset is a pin: synchronise before use
    pin_sync u_hard_sync (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_async(i_hard_reset_pin),
        .o_sync(hard_reset_sync)
    );

    // treat the synchronised level as held; clear repeats each cycle while high
    assign hard_rise = hard_reset_sync;

    // qualified data strobes, shared by the access checks
    assign cfg_wr = i_config_state & i_data_wr;
    assign cfg_rd = i_config_state & i_data_rd;

    // register writes, reads and hardware reset clearing
    always_comb begin
        next_state = state;
        next_state.rdata_valid = 1'b0;
        // parallel-port floppy path ignores the setup tristate/type bits
        next_state.pport_density = i_pport_floppy_active & i_density_func;
        if (i_config_state && i_index_wr) begin
            next_state.config_index_reg = i_wdata;
        end
        if (i_config_state && i_data_wr) begin
            case (state.config_index_reg)
                IDX_DRIVE_TYPE_ID: next_state.drive_type_id = i_wdata;
                IDX_AUTO_PD_BOOT: next_state.auto_powerdown_boot_select = i_wdata & AUTO_PD_WMASK;
                IDX_TEST_CONTROL: next_state.test_control = i_wdata;
                default: ;
            endcase
        end
        // hard reset clears only the power-down enables, beats a write
        if (hard_rise) begin
            next_state.auto_powerdown_boot_select = next_state.auto_powerdown_boot_select & AUTO_PD_HARD_KEEP;
        end
        if (i_config_state && i_data_rd) begin
            next_state.rdata_valid = 1'b1;
            case (state.config_index_reg)
                IDX_DRIVE_TYPE_ID: next_state.rdata = state.drive_type_id;
                IDX_AUTO_PD_BOOT: next_state.rdata = state.auto_powerdown_boot_select & AUTO_PD_WMASK;
                IDX_RESERVED_SLOT: next_state.rdata = RST_RESERVED_SLOT;
                IDX_TEST_CONTROL: next_state.rdata = state.test_control;
                default: next_state.rdata = 8'h00;
            endcase
        end
    end

    // power-on reset loads documented defaults
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state.config_index_reg <= RST_CONFIG_INDEX;
            state.drive_type_id <= RST_DRIVE_TYPE_ID;
            state.auto_powerdown_boot_select <= RST_AUTO_PD_BOOT;
            state.test_control <= RST_TEST_CONTROL;
            state.rdata <= RST_RDATA;
            state.rdata_valid <= 1'b0;
            state.pport_density <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // per-drive type id slices, low bit first
    genvar g;
    generate
        for (g = 0; g < NUM_DRIVES; g++) begin : g_drive
            assign drive_type[g] = state.drive_type_id[g*TYPE_ID_W +: TYPE_ID_W];
        end
    endgenerate

    density_gate u_density (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_outputs_tristate(i_floppy_outputs_tristate),
        .i_density_force_high(i_density_override),
        .i_density_func(i_density_func),
        .o_density_select_out(o_density_select_out),
        .o_density_select_oe_n(o_density_select_oe_n)
    );

    // outputs straight from the state register
    assign o_rdata = state.rdata;
    assign o_rdata_valid = state.rdata_valid;
    assign o_pport_density_out = state.pport_density;
    assign o_drive_type_id = state.drive_type_id;
    assign o_drive0_type = drive_type[0];
    assign o_drive1_type = drive_type[1];
    assign o_drive2_type = drive_type[2];
    assign o_drive3_type = drive_type[3];
    assign o_boot_floppy = state.auto_powerdown_boot_select[BOOT_LO +: 2];
    assign o_boot_drive_b = state.auto_powerdown_boot_select[BOOT_LO];
    assign o_pd_parallel_en = state.auto_powerdown_boot_select[PD_PAR_BIT];
    assign o_pd_second_serial_en = state.auto_powerdown_boot_select[PD_SECOND_SERIAL_PORT_BIT];
    assign o_pd_first_serial_en = state.auto_powerdown_boot_select[PD_FIRST_SERIAL_PORT_BIT];
    assign o_pd_floppy_en = state.auto_powerdown_boot_select[PD_FDC_BIT];
    // test bits are stored only; nothing here acts on them
    assign o_test_control = state.test_control;

    property p_wr_drive_id;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_config_state && i_data_wr && state.config_index_reg == IDX_DRIVE_TYPE_ID)
            |=> (o_drive_type_id == $past(i_wdata));
    endproperty
    a_wr_drive_id: assert property (p_wr_drive_id) else $error("drive type id write lost");

    property p_no_cfg_no_write;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (!i_config_state && !hard_rise) |=> $stable(o_drive_type_id) && $stable(o_pd_floppy_en) && $stable(o_test_control);
    endproperty
    a_no_cfg_no_write: assert property (p_no_cfg_no_write) else $error("register changed outside config state");

    property p_hard_clear;
        @(posedge i_core_clk) disable iff (!i_nrst)
        hard_rise |=> (state.auto_powerdown_boot_select[7:4] == 4'h0);
    endproperty
    a_hard_clear: assert property (p_hard_clear) else $error("hard reset left power-down bits set");

    property p_hard_keep_low;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (hard_rise && !(i_config_state && i_data_wr))
            |=> (o_boot_floppy == $past(o_boot_floppy));
    endproperty
    a_hard_keep_low: assert property (p_hard_keep_low) else $error("hard reset disturbed boot field");

    property p_rsvd_zero;
        @(posedge i_core_clk) disable iff (!i_nrst)
        state.auto_powerdown_boot_select[3:2] == 2'b00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved power bits set");

    property p_rd_slot;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_config_state && i_data_rd && state.config_index_reg == IDX_RESERVED_SLOT)
            |=> (o_rdata_valid && o_rdata == 8'h00);
    endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("reserved slot read nonzero");

    property p_rd_test;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_config_state && i_data_rd && state.config_index_reg == IDX_TEST_CONTROL)
            |=> (o_rdata == $past(o_test_control));
    endproperty
    a_rd_test: assert property (p_rd_test) else $error("test register read mismatch");

    property p_drive_slice;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && state.config_index_reg == IDX_DRIVE_TYPE_ID)
            |=> ({o_drive3_type, o_drive2_type, o_drive1_type, o_drive0_type} == $past(i_wdata));
    endproperty
    a_drive_slice: assert property (p_drive_slice) else $error("drive id slice wrong");

    property p_pport;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_pport_floppy_active && i_floppy_outputs_tristate) |=> (o_pport_density_out == $past(i_density_func));
    endproperty
    a_pport: assert property (p_pport) else $error("parallel floppy gated by setup bits");

    // write path: each field takes the written bits one cycle later
    property p_boot_wr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (o_boot_floppy == $past(i_wdata[BOOT_LO +: 2]));
    endproperty
    a_boot_wr: assert property (p_boot_wr) else $error("boot field write lost");

    property p_pd_par_wr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && !hard_rise && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (o_pd_parallel_en == $past(i_wdata[PD_PAR_BIT]));
    endproperty
    a_pd_par_wr: assert property (p_pd_par_wr) else $error("parallel power-down bit wrong");

    property p_pd_s2_wr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && !hard_rise && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (o_pd_second_serial_en == $past(i_wdata[PD_SECOND_SERIAL_PORT_BIT]));
    endproperty
    a_pd_s2_wr: assert property (p_pd_s2_wr) else $error("second serial power-down bit wrong");

    property p_pd_s1_wr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && !hard_rise && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (o_pd_first_serial_en == $past(i_wdata[PD_FIRST_SERIAL_PORT_BIT]));
    endproperty
    a_pd_s1_wr: assert property (p_pd_s1_wr) else $error("first serial power-down bit wrong");

    property p_pd_fdc_wr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && !hard_rise && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (o_pd_floppy_en == $past(i_wdata[PD_FDC_BIT]));
    endproperty
    a_pd_fdc_wr: assert property (p_pd_fdc_wr) else $error("floppy power-down bit wrong");

    property p_wr_test;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && state.config_index_reg == IDX_TEST_CONTROL)
            |=> (o_test_control == $past(i_wdata));
    endproperty
    a_wr_test: assert property (p_wr_test) else $error("test register write lost");

    // read path: one-cycle valid, data held until the next read
    property p_rd_drive_id;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_rd && state.config_index_reg == IDX_DRIVE_TYPE_ID)
            |=> (o_rdata_valid && o_rdata == $past(o_drive_type_id));
    endproperty
    a_rd_drive_id: assert property (p_rd_drive_id) else $error("drive type id read mismatch");

    property p_rd_pwr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_rd && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (o_rdata == {$past(o_pd_floppy_en), $past(o_pd_first_serial_en), $past(o_pd_second_serial_en),
                $past(o_pd_parallel_en), 2'b00, $past(o_boot_floppy)});
    endproperty
    a_rd_pwr: assert property (p_rd_pwr) else $error("power register read mismatch");

    property p_rd_valid;
        @(posedge i_core_clk) disable iff (!i_nrst)
        cfg_rd |=> o_rdata_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");

    property p_no_rd_valid;
        @(posedge i_core_clk) disable iff (!i_nrst)
        !cfg_rd |=> !o_rdata_valid;
    endproperty
    a_no_rd_valid: assert property (p_no_rd_valid) else $error("read valid without a read");

    property p_rdata_hold;
        @(posedge i_core_clk) disable iff (!i_nrst)
        !cfg_rd |=> $stable(o_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    property p_index_gate;
        @(posedge i_core_clk) disable iff (!i_nrst)
        !i_config_state |=> $stable(state.config_index_reg);
    endproperty
    a_index_gate: assert property (p_index_gate) else $error("index loaded outside config state");

    property p_rd_unmapped;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_rd && (state.config_index_reg < IDX_DRIVE_TYPE_ID || state.config_index_reg > IDX_TEST_CONTROL))
            |=> (o_rdata == 8'h00);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped index read nonzero");

    property p_slot_no_store;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (cfg_wr && state.config_index_reg == IDX_RESERVED_SLOT)
            |=> ($stable(o_drive_type_id) && $stable(o_test_control) && $stable(o_boot_floppy));
    endproperty
    a_slot_no_store: assert property (p_slot_no_store) else $error("reserved slot write stored");

    // hard reset wins over a write landing in the same cycle
    property p_hard_beats_wr;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (hard_rise && cfg_wr && state.config_index_reg == IDX_AUTO_PD_BOOT)
            |=> (state.auto_powerdown_boot_select[PD_FDC_BIT:PD_PAR_BIT] == 4'h0);
    endproperty
    a_hard_beats_wr: assert property (p_hard_beats_wr) else $error("write beat hard reset");

    property p_pport_off;
        @(posedge i_core_clk) disable iff (!i_nrst)
        !i_pport_floppy_active |=> !o_pport_density_out;
    endproperty
    a_pport_off: assert property (p_pport_off) else $error("parallel density driven while idle");

    property p_pport_setup;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_pport_floppy_active && !i_floppy_outputs_tristate)
            |=> (o_pport_density_out == $past(i_density_func));
    endproperty
    a_pport_setup: assert property (p_pport_setup) else $error("parallel density not following");
endmodule : fdd_power_config_regs

/* File: cfg_regs_pkg.sv */
// configuration register slice: offsets, field positions, reset values
// assumes an 8-bit configuration index/data access from the config port
package cfg_regs_pkg;
    // configuration index values
    localparam logic [7:0] IDX_DRIVE_TYPE_ID = 8'h06;
    localparam logic [7:0] IDX_AUTO_PD_BOOT = 8'h07;
    localparam logic [7:0] IDX_RESERVED_SLOT = 8'h08;
    localparam logic [7:0] IDX_TEST_CONTROL = 8'h09;
    // reset values
    localparam logic [7:0] RST_DRIVE_TYPE_ID = 8'hFF;
    localparam logic [7:0] RST_AUTO_PD_BOOT = 8'h00;
    localparam logic [7:0] RST_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_RESERVED_SLOT = 8'h00;
    localparam logic [7:0] RST_CONFIG_INDEX = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;
    // power management field positions
    localparam int BOOT_LO = 0;
    localparam int PD_PAR_BIT = 4;
    localparam int PD_SECOND_SERIAL_PORT_BIT = 5;
    localparam int PD_FIRST_SERIAL_PORT_BIT = 6;
    localparam int PD_FDC_BIT = 7;
    localparam logic [7:0] AUTO_PD_WMASK = 8'hF3;
    localparam logic [7:0] AUTO_PD_HARD_KEEP = 8'h0F;
    // drive type id layout
    localparam int NUM_DRIVES = 4;
    localparam int TYPE_ID_W = 2;
    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
endpackage : cfg_regs_pkg

/* File: pin_sync.sv */
// two-flop synchroniser for asynchronous pin levels
// assumes a single core clock; first stage read only by the second
`timescale 1ns/10ps
module pin_sync (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // level in and out
    input wire logic i_async,
    output logic o_sync
);
    import cfg_regs_pkg::*;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // shift the pin through two stages
    always_comb begin
        next_state.meta = i_async;
        next_state.stable = state.meta;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.stable;
endmodule : pin_sync

/* File: density_gate.sv */
// density select pin gating: forced high, normal or released
// assumes all inputs are on the core clock
`timescale 1ns/10ps
module density_gate (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // control
    input wire logic i_outputs_tristate,
    input wire logic i_density_force_high,
    input wire logic i_density_func,
    // pin
    output logic o_density_select_out,
    output logic o_density_select_oe_n
);
    import cfg_regs_pkg::*;

    typedef struct packed {
        logic pin;
        logic oe_n;
    } gate_state_t;

    gate_state_t state;
    gate_state_t next_state;

    // tristate wins over the force bit
    always_comb begin
        next_state.oe_n = i_outputs_tristate;
        if (i_outputs_tristate) begin
            next_state.pin = 1'b0;
        end else if (i_density_force_high) begin
            next_state.pin = 1'b1;
        end else begin
            next_state.pin = i_density_func;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '{pin: 1'b0, oe_n: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign o_density_select_out = state.pin;
    assign o_density_select_oe_n = state.oe_n;

    property p_force_high;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (!i_outputs_tristate && i_density_force_high) |=> (o_density_select_out && !o_density_select_oe_n);
    endproperty
    a_force_high: assert property (p_force_high) else $error("density pin not forced high");

    property p_follow;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (!i_outputs_tristate && !i_density_force_high) |=> (o_density_select_out == $past(i_density_func));
    endproperty
    a_follow: assert property (p_follow) else $error("density pin not following function");

    property p_tristate;
        @(posedge i_core_clk) disable iff (!i_nrst)
        i_outputs_tristate |=> o_density_select_oe_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("density pin driven while tristated");
endmodule : density_gate

/* File: tb.sv */
// self-checking bench for the drive type, power-down and test registers
// assumes one core clock; the bench drives all config port strobes itself
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    import cfg_regs_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_hard_reset_pin = 1'b0;
    logic i_config_state = 1'b0;
    logic i_index_wr = 1'b0;
    logic i_data_wr = 1'b0;
    logic i_data_rd = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_floppy_outputs_tristate = 1'b0;
    logic i_density_override = 1'b0;
    logic i_density_func = 1'b0;
    logic i_pport_floppy_active = 1'b0;
    logic [7:0] o_rdata, o_drive_type_id, o_test_control;
    logic o_rdata_valid, o_density_select_out, o_density_select_oe_n, o_pport_density_out;
    logic [1:0] o_drive0_type, o_drive1_type, o_drive2_type, o_drive3_type, o_boot_floppy;
    logic o_boot_drive_b, o_pd_parallel_en, o_pd_second_serial_en, o_pd_first_serial_en, o_pd_floppy_en;
    logic [7:0] rd;
    logic [2:0] c;
    int bad_count = 0;
    int samples_checked = 0;
    fdd_power_config_regs fdd_power_config_regs_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_hard_reset_pin(i_hard_reset_pin), .i_config_state(i_config_state), .i_index_wr(i_index_wr),
        .i_data_wr(i_data_wr), .i_data_rd(i_data_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rdata_valid(o_rdata_valid), .i_floppy_outputs_tristate(i_floppy_outputs_tristate),
        .i_density_override(i_density_override), .i_density_func(i_density_func),
        .i_pport_floppy_active(i_pport_floppy_active), .o_density_select_out(o_density_select_out),
        .o_density_select_oe_n(o_density_select_oe_n), .o_pport_density_out(o_pport_density_out),
        .o_drive_type_id(o_drive_type_id), .o_drive0_type(o_drive0_type), .o_drive1_type(o_drive1_type),
        .o_drive2_type(o_drive2_type), .o_drive3_type(o_drive3_type), .o_boot_floppy(o_boot_floppy),
        .o_boot_drive_b(o_boot_drive_b), .o_pd_parallel_en(o_pd_parallel_en),
        .o_pd_second_serial_en(o_pd_second_serial_en), .o_pd_first_serial_en(o_pd_first_serial_en),
        .o_pd_floppy_en(o_pd_floppy_en), .o_test_control(o_test_control));
    // 250 MHz core clock
    initial begin
        forever #2 i_core_clk = ~i_core_clk;
    end
    // index load, then one data strobe on the following edge
    task automatic set_index(input logic [7:0] idx);
        @(posedge i_core_clk) #1;
        i_index_wr = 1'b1;
        i_wdata = idx;
        @(posedge i_core_clk) #1;
        i_index_wr = 1'b0;
    endtask : set_index
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        set_index(idx);
        i_data_wr = 1'b1;
        i_wdata = d;
        @(posedge i_core_clk) #1;
        i_data_wr = 1'b0;
        @(posedge i_core_clk) #1;
    endtask : wr_reg
    // read data is taken in the single cycle that valid stands
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
        set_index(idx);
        i_data_rd = 1'b1;
        @(posedge i_core_clk) #1;
        i_data_rd = 1'b0;
        `CHK(o_rdata_valid, 1'b1)
        d = o_rdata;
        @(posedge i_core_clk) #1;
        `CHK(o_rdata_valid, 1'b0)
    endtask : rd_reg
    task automatic check_reg(input logic [7:0] idx, input logic [7:0] exp);
        rd_reg(idx, rd);
        `CHK(rd, exp)
    endtask : check_reg
    // power-on values of every register in the slice
    task automatic check_defaults();
        check_reg(IDX_DRIVE_TYPE_ID, 8'hFF);
        check_reg(IDX_AUTO_PD_BOOT, 8'h00);
        check_reg(IDX_RESERVED_SLOT, 8'h00);
        check_reg(IDX_TEST_CONTROL, 8'h00);
        `CHK(o_drive_type_id, 8'hFF)
        `CHK(o_pd_floppy_en, 1'b0)
        `CHK(o_boot_floppy, 2'h0)
    endtask : check_defaults
    task automatic finish_test();
        $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #40000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge i_core_clk);
        `CHK(o_density_select_oe_n, 1'b1)
        #1 i_nrst = 1'b1;
        i_config_state = 1'b1;
        check_defaults();
        check_reg(8'h0A, 8'h00);
        // per-drive id fields, low bit first
        wr_reg(IDX_DRIVE_TYPE_ID, 8'hE4);
        `CHK({o_drive3_type, o_drive2_type, o_drive1_type, o_drive0_type}, 8'hE4)
        `CHK(o_drive0_type, 2'h0)
        `CHK(o_drive3_type, 2'h3)
        check_reg(IDX_DRIVE_TYPE_ID, 8'hE4);
        // reserved bits 2 and 3 drop writes
        wr_reg(IDX_AUTO_PD_BOOT, 8'hF7);
        check_reg(IDX_AUTO_PD_BOOT, 8'hF3);
        // each power-down enable alone, with boot drive B then A
        for (int b = 4; b < 8; b++) begin
            wr_reg(IDX_AUTO_PD_BOOT, (8'h01 << b) | 8'h0D);
            `CHK(o_pd_parallel_en, 1'(b == 4))
            `CHK(o_pd_second_serial_en, 1'(b == 5))
            `CHK(o_pd_first_serial_en, 1'(b == 6))
            `CHK(o_pd_floppy_en, 1'(b == 7))
            `CHK(o_boot_floppy, 2'h1)
            `CHK(o_boot_drive_b, 1'b1)
            check_reg(IDX_AUTO_PD_BOOT, (8'h01 << b) | 8'h01);
        end
        wr_reg(IDX_AUTO_PD_BOOT, 8'hF2);
        `CHK(o_boot_drive_b, 1'b0)
        // hardware reset clears only the upper nibble, and beats a write landing meanwhile
        i_hard_reset_pin = 1'b1;
        repeat (5) @(posedge i_core_clk);
        #1;
        `CHK(o_pd_floppy_en, 1'b0)
        `CHK(o_boot_floppy, 2'h2)
        wr_reg(IDX_AUTO_PD_BOOT, 8'hF2);
        i_hard_reset_pin = 1'b0;
        repeat (4) @(posedge i_core_clk);
        check_reg(IDX_AUTO_PD_BOOT, 8'h02);
        check_reg(IDX_DRIVE_TYPE_ID, 8'hE4);
        wr_reg(IDX_RESERVED_SLOT, 8'hFF);
        check_reg(IDX_RESERVED_SLOT, 8'h00);
        wr_reg(IDX_TEST_CONTROL, 8'h5A);
        `CHK(o_test_control, 8'h5A)
        check_reg(IDX_TEST_CONTROL, 8'h5A);
        wr_reg(IDX_TEST_CONTROL, 8'h00);
        // outside configuration state strobes are ignored
        wr_reg(IDX_DRIVE_TYPE_ID, 8'h11);
        i_config_state = 1'b0;
        wr_reg(IDX_AUTO_PD_BOOT, 8'hF0);
        wr_reg(IDX_TEST_CONTROL, 8'h33);
        i_config_state = 1'b1;
        `CHK(o_drive_type_id, 8'h11)
        check_reg(IDX_DRIVE_TYPE_ID, 8'h11);
        check_reg(IDX_AUTO_PD_BOOT, 8'h02);
        check_reg(IDX_TEST_CONTROL, 8'h00);
        // density pin over all control combinations, pin path one register deep
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            @(posedge i_core_clk) #1;
            i_floppy_outputs_tristate = c[2];
            i_density_override = c[1];
            i_density_func = c[0];
            i_pport_floppy_active = 1'b1;
            repeat (2) @(posedge i_core_clk);
            #1;
            `CHK(o_density_select_oe_n, c[2])
            `CHK(o_density_select_out, ~c[2] & (c[1] | c[0]))
            `CHK(o_pport_density_out, c[0])
        end
        i_pport_floppy_active = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK(o_pport_density_out, 1'b0)
        // second power-on reset in mid-run restores all defaults
        i_nrst = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1 i_nrst = 1'b1;
        check_defaults();
        finish_test();
    end
endmodule : tb
